// [logic/cap_regs_pkg.sv]
/*
  Offsets, field positions and reset values of the power management and
  message interrupt capability registers of one switch port.
  Assumes byte addressed configuration space, one aligned dword per offset.
*/
package cap_regs_pkg;
  // ----------------------------------------
  // Offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_POWER_CAP = 8'h40;
  localparam logic [7:0] OFS_POWER_CSR = 8'h44;
  localparam logic [7:0] OFS_MSG_CAP   = 8'h4c;
  localparam logic [7:0] OFS_MSG_ADDR  = 8'h50;
  // ----------------------------------------
  // Fixed and reset values
  // ----------------------------------------
  localparam logic [7:0] POWER_CAP_ID  = 8'h01;
  localparam logic [7:0] MSG_CAP_ID    = 8'h05;
  localparam logic [7:0] NEXT_UP       = 8'h5c;
  localparam logic [7:0] NEXT_DOWN     = 8'h4c;
  localparam logic [7:0] MSG_NEXT      = 8'h64;
  localparam logic [2:0] POWER_REV     = 3'h3;
  localparam logic [2:0] AUX_RST       = 3'h7;
  localparam logic [4:0] WAKE_SUP_RST  = 5'h1f;
  localparam logic [7:0] DATA_RST      = 8'h00;
  localparam logic [3:0] SEL_RST       = 4'h0;
  localparam logic [1:0] SCALE_RST     = 2'h0;
  localparam logic [2:0] MULTI_CAP     = 3'h0;
  localparam logic [2:0] MULTI_EN_RST  = 3'h0;
  localparam logic [29:0] ADDR_RST     = 30'h0;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int NEXT_LSB = 8;
  localparam int REV_LSB  = 16;
  localparam int DSI_BIT  = 21;
  localparam int AUX_LSB  = 22;
  localparam int D1_BIT   = 25;
  localparam int D2_BIT   = 26;
  localparam int WSUP_LSB = 27;
  localparam int PST_LSB  = 0;
  localparam int NSR_BIT  = 3;
  localparam int WEN_BIT  = 8;
  localparam int SEL_LSB  = 9;
  localparam int SCL_LSB  = 13;
  localparam int DATA_LSB = 24;
  localparam int MEN_BIT  = 16;
  localparam int MMC_LSB  = 17;
  localparam int MME_LSB  = 20;
  localparam int A64_BIT  = 23;
  localparam int ADR_LSB  = 2;
  // ----------------------------------------
  // Preset selects and power states
  // ----------------------------------------
  localparam logic [2:0] SEL_DSI  = 3'h0;
  localparam logic [2:0] SEL_AUX  = 3'h1;
  localparam logic [2:0] SEL_D1   = 3'h2;
  localparam logic [2:0] SEL_D2   = 3'h3;
  localparam logic [2:0] SEL_WSUP = 3'h4;
  localparam logic [2:0] SEL_NSR  = 3'h5;
  localparam logic [2:0] SEL_DATA = 3'h6;
  typedef enum logic [1:0] {
    PWR_D0 = 2'h0, PWR_D1 = 2'h1, PWR_D2 = 2'h2, PWR_D3HOT = 2'h3
  } power_state_type;
endpackage

// [logic/cap_default_if.sv]
/*
  Carrier of the loadable read-only capability defaults.
  Assumes one driver (the default store) and one reader (the register bank).
*/
interface cap_default_if;
  logic       dsi;
  logic [2:0] aux;
  logic       d1;
  logic       d2;
  logic [4:0] wake_sup;
  logic       no_soft_reset;
  logic [7:0] data_byte;
  modport store (output dsi, aux, d1, d2, wake_sup, no_soft_reset, data_byte);
  modport user  (input  dsi, aux, d1, d2, wake_sup, no_soft_reset, data_byte);
endinterface

// [logic/cap_default_store.sv]
/*
  Store of the loadable read-only defaults, written by the preset loader.
  Assumes the loader runs on ref_clk and finishes before enumeration.
*/
module cap_default_store (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Preset loader
  input  wire logic       load_wr,
  input  wire logic [2:0] load_sel,
  input  wire logic [7:0] load_data,
  // Defaults
  cap_default_if.store    dflt
);
  function automatic logic hit(input logic [2:0] s);
    return load_wr && (load_sel == s);
  endfunction

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dflt.dsi           <= 1'b0;
      dflt.aux           <= cap_regs_pkg::AUX_RST;
      dflt.d1            <= 1'b1;
      dflt.d2            <= 1'b1;
      dflt.wake_sup      <= cap_regs_pkg::WAKE_SUP_RST;
      dflt.no_soft_reset <= 1'b1;
      dflt.data_byte     <= cap_regs_pkg::DATA_RST;
    end else begin
      if (hit(cap_regs_pkg::SEL_DSI))  dflt.dsi <= load_data[0];
      if (hit(cap_regs_pkg::SEL_AUX))  dflt.aux <= load_data[2:0];
      if (hit(cap_regs_pkg::SEL_D1))   dflt.d1 <= load_data[0];
      if (hit(cap_regs_pkg::SEL_D2))   dflt.d2 <= load_data[0];
      if (hit(cap_regs_pkg::SEL_WSUP)) dflt.wake_sup <= load_data[4:0];
      if (hit(cap_regs_pkg::SEL_NSR))  dflt.no_soft_reset <= load_data[0];
      if (hit(cap_regs_pkg::SEL_DATA)) dflt.data_byte <= load_data;
    end
  end
endmodule // cap_default_store

// [logic/power_state_ctrl.sv]
/*
  Power state field and the resets that leaving D3hot causes.
  Assumes writes arrive as single-cycle strobes on ref_clk.
*/
module power_state_ctrl (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Field write
  input  wire logic       state_wr,
  input  wire logic [1:0] state_wdata,
  input  wire logic       no_soft_reset,
  // Results
  output logic      [1:0] state,
  output logic            hot_reset,
  output logic            soft_reset
);
  logic leave_d3;

  // Only D3hot exists here; D3cold would wipe this logic anyway
  assign leave_d3 = state_wr && (state == cap_regs_pkg::PWR_D3HOT) &&
                    (state_wdata == cap_regs_pkg::PWR_D0);

  always_ff @(posedge ref_clk) begin
    if (srst) state <= cap_regs_pkg::PWR_D0;
    else if (state_wr) state <= state_wdata;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hot_reset  <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      hot_reset  <= leave_d3;
      soft_reset <= leave_d3 && !no_soft_reset;
    end
  end
endmodule // power_state_ctrl

// [logic/pm_msi_cfg_regs.sv]
/*
  Power management and message interrupt capability registers of one
  switch port, reached through configuration reads and writes.
  Assumes a configuration engine and a preset loader on ref_clk, and
  that the port's role is fixed by the DOWNSTREAM parameter.
*/

module pm_msi_cfg_regs #(
  parameter bit DOWNSTREAM = 1'b1
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Configuration access
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rd_done,
  // Preset loader
  input  wire logic        preset_wr,
  input  wire logic [2:0]  preset_sel,
  input  wire logic [7:0]  preset_data,
  // Power management
  output logic      [1:0]  power_state,
  output logic             hot_reset,
  output logic             internal_reset,
  output logic             downstream_reset_out,
  output logic             power_wake_message,
  // Message interrupts
  output logic             msg_irq_enable,
  output logic             intx_allowed,
  output logic      [2:0]  msg_multi_enable,
  output logic      [31:0] msg_address,
  output logic             msg_addr64_active
);

  // ----------------------------------------
  // Port role
  // ----------------------------------------
  // Role is fixed at build time; a port cannot change it later
  localparam logic [7:0] NEXT_PTR = DOWNSTREAM ? cap_regs_pkg::NEXT_DOWN
                                               : cap_regs_pkg::NEXT_UP;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Bits 1:0 pick a byte inside the word, never a register
  function automatic logic word_hit(input logic [7:0] a,
                                    input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  function automatic logic lane_on(input logic [3:0] be,
                                   input int pos);
    return be[pos / 8];
  endfunction

  // Lanes whose enable is clear keep their old byte
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic wr_csr;
  logic wr_msg_cap;
  logic wr_msg_addr;
  logic rd_hit_cap;
  logic rd_hit_csr;
  logic rd_hit_mcap;
  logic rd_hit_madr;

  assign wr_csr = cfg_wr && word_hit(cfg_addr, cap_regs_pkg::OFS_POWER_CSR);
  // Upstream has no message capability: those words drop writes
  assign wr_msg_cap  = DOWNSTREAM && cfg_wr &&
                       word_hit(cfg_addr, cap_regs_pkg::OFS_MSG_CAP);
  assign wr_msg_addr = DOWNSTREAM && cfg_wr &&
                       word_hit(cfg_addr, cap_regs_pkg::OFS_MSG_ADDR);
  assign rd_hit_cap  = word_hit(cfg_addr, cap_regs_pkg::OFS_POWER_CAP);
  assign rd_hit_csr  = word_hit(cfg_addr, cap_regs_pkg::OFS_POWER_CSR);
  assign rd_hit_mcap = DOWNSTREAM &&
                       word_hit(cfg_addr, cap_regs_pkg::OFS_MSG_CAP);
  assign rd_hit_madr = DOWNSTREAM &&
                       word_hit(cfg_addr, cap_regs_pkg::OFS_MSG_ADDR);

  // ----------------------------------------
  // Field write strobes
  // ----------------------------------------
  // One strobe per writable field, so a lane left out keeps its field
  logic wr_wen;
  logic wr_sel;
  logic wr_men;
  logic wr_mme;

  assign wr_wen = wr_csr && lane_on(cfg_be, cap_regs_pkg::WEN_BIT);
  assign wr_sel = wr_csr && lane_on(cfg_be, cap_regs_pkg::SEL_LSB);
  assign wr_men = wr_msg_cap && lane_on(cfg_be, cap_regs_pkg::MEN_BIT);
  assign wr_mme = wr_msg_cap && lane_on(cfg_be, cap_regs_pkg::MME_LSB);

  // ----------------------------------------
  // Loadable defaults
  // ----------------------------------------
  // Presets may land at any time; enumeration should wait for them
  cap_default_if dflt ();

  cap_default_store u_store (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .load_wr   (preset_wr),
    .load_sel  (preset_sel),
    .load_data (preset_data),
    .dflt      (dflt.store)
  );

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  logic       state_wr;
  logic [1:0] state_q;
  logic       hot_q;
  logic       soft_q;

  assign state_wr = wr_csr && lane_on(cfg_be, cap_regs_pkg::PST_LSB);

  // Pulses last one cycle; whoever listens must act on a single edge
  power_state_ctrl u_pwr (
    .ref_clk       (ref_clk),
    .srst          (srst),
    .state_wr      (state_wr),
    .state_wdata   (cfg_wdata[cap_regs_pkg::PST_LSB +: 2]),
    .no_soft_reset (dflt.no_soft_reset),
    .state         (state_q),
    .hot_reset     (hot_q),
    .soft_reset    (soft_q)
  );

  assign power_state    = state_q;
  assign hot_reset      = hot_q;
  assign internal_reset = soft_q;

  // Hot reset of this port never reaches the downstream reset pin
  always_ff @(posedge ref_clk) begin
    if (srst) downstream_reset_out <= 1'b0;
    else downstream_reset_out <= 1'b0;
  end

  // ----------------------------------------
  // Power control writable fields
  // ----------------------------------------
  logic       wake_en;
  logic [3:0] data_sel;

  always_ff @(posedge ref_clk) begin
    if (srst || soft_q) begin
      wake_en <= 1'b0;
    end else if (wr_wen) begin
      wake_en <= cfg_wdata[cap_regs_pkg::WEN_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || soft_q) begin
      data_sel <= cap_regs_pkg::SEL_RST;
    end else if (wr_sel) begin
      data_sel <= cfg_wdata[cap_regs_pkg::SEL_LSB +: 4];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) power_wake_message <= 1'b0;
    else power_wake_message <= wake_en;
  end

  // ----------------------------------------
  // Message interrupt writable fields
  // ----------------------------------------
  logic        men;
  logic [2:0]  mme;
  logic [29:0] madr;
  logic [31:0] madr_merged;

  assign madr_merged = be_merge({madr, 2'h0}, cfg_wdata, cfg_be);

  always_ff @(posedge ref_clk) begin
    if (srst || soft_q) begin
      men <= 1'b0;
    end else if (wr_men) begin
      men <= cfg_wdata[cap_regs_pkg::MEN_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || soft_q) begin
      mme <= cap_regs_pkg::MULTI_EN_RST;
    end else if (wr_mme) begin
      mme <= cfg_wdata[cap_regs_pkg::MME_LSB +: 3];
    end
  end

  // Bits 1:0 are never stored, so the target stays dword aligned
  always_ff @(posedge ref_clk) begin
    if (srst || soft_q) begin
      madr <= cap_regs_pkg::ADDR_RST;
    end else if (wr_msg_addr) begin
      madr <= madr_merged[31:cap_regs_pkg::ADR_LSB];
    end
  end

  // ----------------------------------------
  // Message interrupt outputs
  // ----------------------------------------
  // Reset leaves INTx usable until software turns messages on
  always_ff @(posedge ref_clk) begin
    if (srst) msg_irq_enable <= 1'b0;
    else msg_irq_enable <= men;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) intx_allowed <= 1'b1;
    else intx_allowed <= !men;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) msg_multi_enable <= cap_regs_pkg::MULTI_EN_RST;
    else msg_multi_enable <= mme;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) msg_address <= 32'h0;
    else msg_address <= {madr, 2'h0};
  end

  // Wide addressing is fixed on, so its use follows the enable alone
  always_ff @(posedge ref_clk) begin
    if (srst) msg_addr64_active <= 1'b0;
    else msg_addr64_active <= men;
  end

  // ----------------------------------------
  // Read words
  // ----------------------------------------
  logic [31:0] cap_word;
  logic [31:0] csr_word;
  logic [31:0] mcap_word;
  logic [31:0] madr_word;
  logic [31:0] read_word;

  // Everything not named below stays zero
  always_comb begin
    cap_word = 32'h0;
    cap_word[7:0] = cap_regs_pkg::POWER_CAP_ID;
    cap_word[cap_regs_pkg::NEXT_LSB +: 8] = NEXT_PTR;
    cap_word[cap_regs_pkg::REV_LSB +: 3] = cap_regs_pkg::POWER_REV;
    cap_word[cap_regs_pkg::DSI_BIT] = dflt.dsi;
    cap_word[cap_regs_pkg::AUX_LSB +: 3] = dflt.aux;
    cap_word[cap_regs_pkg::D1_BIT] = dflt.d1;
    cap_word[cap_regs_pkg::D2_BIT] = dflt.d2;
    cap_word[cap_regs_pkg::WSUP_LSB +: 5] = dflt.wake_sup;
  end

  // Bits 15, 19, 22 and 23 have no storage, so writes vanish
  always_comb begin
    csr_word = 32'h0;
    csr_word[cap_regs_pkg::PST_LSB +: 2] = state_q;
    csr_word[cap_regs_pkg::NSR_BIT] = dflt.no_soft_reset;
    csr_word[cap_regs_pkg::WEN_BIT] = wake_en;
    csr_word[cap_regs_pkg::SEL_LSB +: 4] = data_sel;
    csr_word[cap_regs_pkg::SCL_LSB +: 2] = cap_regs_pkg::SCALE_RST;
    csr_word[cap_regs_pkg::DATA_LSB +: 8] = dflt.data_byte;
  end

  always_comb begin
    mcap_word = 32'h0;
    mcap_word[7:0] = cap_regs_pkg::MSG_CAP_ID;
    mcap_word[cap_regs_pkg::NEXT_LSB +: 8] = cap_regs_pkg::MSG_NEXT;
    mcap_word[cap_regs_pkg::MEN_BIT] = men;
    mcap_word[cap_regs_pkg::MMC_LSB +: 3] = cap_regs_pkg::MULTI_CAP;
    mcap_word[cap_regs_pkg::MME_LSB +: 3] = mme;
    mcap_word[cap_regs_pkg::A64_BIT] = 1'b1;
  end

  assign madr_word = {madr, 2'h0};

  // Unmapped words, and the message words on upstream, read zero
  always_comb begin
    read_word = 32'h0;
    if (rd_hit_cap) read_word = cap_word;
    else if (rd_hit_csr) read_word = csr_word;
    else if (rd_hit_mcap) read_word = mcap_word;
    else if (rd_hit_madr) read_word = madr_word;
  end

  // ----------------------------------------
  // Read return
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) cfg_rd_done <= 1'b0;
    else cfg_rd_done <= cfg_rd;
  end

  // A read beside a write in one cycle returns the old values
  always_ff @(posedge ref_clk) begin
    if (srst) cfg_rdata <= 32'h0;
    else if (cfg_rd) cfg_rdata <= read_word;
  end

endmodule // pm_msi_cfg_regs

// [bench/pm_msi_cfg_regs_checker.sv]
/*
  Port checker of the capability register bank.
  Assumes it is bound onto pm_msi_cfg_regs, one clock, srst sync high.
*/
module pm_msi_cfg_regs_checker #(
  parameter bit DOWNSTREAM = 1'b1
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // Configuration access
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_rd_done,
  // Results
  input wire logic [1:0]  power_state,
  input wire logic        hot_reset,
  input wire logic        internal_reset,
  input wire logic        downstream_reset_out,
  input wire logic        power_wake_message,
  input wire logic        msg_irq_enable,
  input wire logic        intx_allowed,
  input wire logic [31:0] msg_address,
  input wire logic        msg_addr64_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ----
  // Steps
  // ----
  sequence s_rd(logic [5:0] dw);
    cfg_rd && cfg_addr[7:2] == dw;
  endsequence
  sequence s_wr(logic [5:0] dw, int lane);
    cfg_wr && cfg_addr[7:2] == dw && cfg_be[lane];
  endsequence
  sequence s_d3_exit;
    s_wr(6'h11, 0) ##0 (cfg_wdata[1:0] == 2'h0 && power_state == 2'h3);
  endsequence
  a_read_answer: assert property (cfg_rd |=> cfg_rd_done) else $error("read not answered");
  a_no_stray: assert property (!cfg_rd |=> !cfg_rd_done) else $error("stray read done");
  a_power_hdr: assert property (s_rd(6'h10) |=> cfg_rdata[7:0] == 8'h01
    && cfg_rdata[15:8] == (DOWNSTREAM ? 8'h4c : 8'h5c) && cfg_rdata[20:16] == 5'h03)
    else $error("power header word wrong");
  a_csr_fixed: assert property (s_rd(6'h11) |=> cfg_rdata[23:13] == 11'h0
    && cfg_rdata[7:4] == 4'h0 && !cfg_rdata[2] && cfg_rdata[1:0] == $past(power_state))
    else $error("control word fixed bits wrong");
  a_msg_hdr: assert property (s_rd(6'h13) |=> cfg_rdata[19:17] == 3'h0
    && cfg_rdata[15:0] == (DOWNSTREAM ? 16'h6405 : 16'h0)
    && cfg_rdata[31:23] == {8'h00, DOWNSTREAM}) else $error("message header wrong");
  a_addr_align: assert property (s_rd(6'h14) |=> cfg_rdata[1:0] == 2'h0
    && msg_address[1:0] == 2'h0) else $error("address low bits set");
  a_hot_entry: assert property (s_d3_exit |=> hot_reset && power_state == 2'h0)
    else $error("no hot reset on leaving D3hot");
  a_hot_cause: assert property (hot_reset |-> $past(cfg_wr)
    && $past(power_state) == 2'h3 && power_state == 2'h0) else $error("spurious hot reset");
  a_soft_gate: assert property (internal_reset |-> hot_reset)
    else $error("internal reset without hot reset");
  a_no_dwn_reset: assert property (!downstream_reset_out)
    else $error("downstream reset driven");
  a_intx_excl: assert property (intx_allowed != msg_irq_enable
    && msg_addr64_active == msg_irq_enable) else $error("interrupt mode inconsistent");
  a_wake_follow: assert property (s_wr(6'h11, 1) ##0 !internal_reset |-> ##2
    power_wake_message == $past(cfg_wdata[8], 2)) else $error("wake enable not followed");
  a_msg_follow: assert property (s_wr(6'h13, 2) ##0 !internal_reset |-> ##2
    msg_irq_enable == (DOWNSTREAM && $past(cfg_wdata[16], 2)))
    else $error("message enable not followed");
endmodule // pm_msi_cfg_regs_checker

bind pm_msi_cfg_regs pm_msi_cfg_regs_checker #(.DOWNSTREAM(DOWNSTREAM)) chk_i (
  .ref_clk, .srst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
  .cfg_rd_done, .power_state, .hot_reset, .internal_reset, .downstream_reset_out,
  .power_wake_message, .msg_irq_enable, .intx_allowed, .msg_address, .msg_addr64_active);

// [bench/cfg_host_model.sv]
/*
  Host issuing configuration reads and writes, driven on the falling edge.
  Assumes the bank answers a read one cycle after it is taken.
*/
module cfg_host_model (
  // Clock
  input  wire logic        ref_clk,
  // Requests
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  // Answers
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rd_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
  end
  // Released bus flips, so a stale value can never look valid
  task automatic idle();
    {cfg_addr, cfg_be, cfg_wdata} = ~{cfg_addr, cfg_be, cfg_wdata};
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge ref_clk);
    {cfg_addr, cfg_be, cfg_wdata, cfg_wr} = {a, be, d, 1'b1};
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    idle();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic done);
    @(negedge ref_clk);
    {cfg_addr, cfg_rd} = {a, 1'b1};
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    done = cfg_rd_done;
    d = cfg_rdata;
    idle();
  endtask
endmodule // cfg_host_model

// [bench/pm_msi_cfg_regs_test.sv]
/*
  Self-checking bench of the capability register bank, both port roles.
  Assumes the host model drives the bus and the bench drives presets.
*/
module pm_msi_cfg_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, srst, cfg_wr, cfg_rd, cfg_rd_done, preset_wr, rdone;
  logic [7:0]  cfg_addr, preset_data, dbyte;
  logic [3:0]  cfg_be, sel;
  logic [31:0] cfg_wdata, cfg_rdata, up_rdata, msg_address, lfsr, rdv, ma;
  logic [2:0]  preset_sel, msg_multi_enable, mme, aux;
  logic [1:0]  power_state, st;
  logic [4:0]  wsup;
  logic        hot_reset, internal_reset, downstream_reset_out, power_wake_message;
  logic        msg_irq_enable, intx_allowed, msg_addr64_active, wen, men, dsi, d1, d2, nsr;
  int          n_errors, total_checks;
  logic [7:0]  ofs_tab [6] = '{8'h40, 8'h44, 8'h4c, 8'h50, 8'h48, 8'h54};
  pm_msi_cfg_regs #(.DOWNSTREAM(1'b1)) pm_msi_cfg_regs_i (.ref_clk, .srst, .cfg_wr,
    .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rd_done, .preset_wr,
    .preset_sel, .preset_data, .power_state, .hot_reset, .internal_reset,
    .downstream_reset_out, .power_wake_message, .msg_irq_enable, .intx_allowed,
    .msg_multi_enable, .msg_address, .msg_addr64_active);
  // Upstream role shares the bus; only its read data is compared
  pm_msi_cfg_regs #(.DOWNSTREAM(1'b0)) up_i (.ref_clk, .srst, .cfg_wr, .cfg_rd,
    .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata(up_rdata), .cfg_rd_done(), .preset_wr,
    .preset_sel, .preset_data, .power_state(), .hot_reset(), .internal_reset(),
    .downstream_reset_out(), .power_wake_message(), .msg_irq_enable(), .intx_allowed(),
    .msg_multi_enable(), .msg_address(), .msg_addr64_active());
  cfg_host_model cfg_host_model_i (.ref_clk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
    .cfg_wdata, .cfg_rdata, .cfg_rd_done);
  // ----
  // Expectations
  // ----
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_word(input logic [7:0] a, input bit dn);
    case (a)
      8'h40: return {wsup, d2, d1, aux, dsi, 5'h03, dn ? 8'h4c : 8'h5c, 8'h01};
      8'h44: return {dbyte, 11'h0, sel, wen, 4'h0, nsr, 1'b0, st};
      8'h4c: return dn ? {8'h00, 1'b1, mme, 3'h0, men, 16'h6405} : 32'h0;
      8'h50: return dn ? {ma[31:2], 2'h0} : 32'h0;
      default: return 32'h0;
    endcase
  endfunction
  task automatic shadow_reset();
    {st, wen, sel, men, mme, ma} = '0;
    {dsi, aux, d1, d2, wsup, nsr, dbyte} = {1'b0, 3'h7, 2'h3, 5'h1f, 1'b1, 8'h00};
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ----
  // Operations
  // ----
  task automatic do_rd(input logic [7:0] a);
    cfg_host_model_i.rd(a, rdv, rdone);
    chk({31'h0, rdone}, 32'h1);
    chk(rdv, exp_word(a, 1'b1));
    chk(up_rdata, exp_word(a, 1'b0));
  endtask
  task automatic do_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic d3x;
    d3x = a == 8'h44 && be[0] && d[1:0] == 2'h0 && st == 2'h3;
    cfg_host_model_i.wr(a, be, d);
    chk({hot_reset, internal_reset}, {d3x, d3x && !nsr});
    if (a == 8'h44 && be[0]) st = d[1:0];
    if (a == 8'h44 && be[1]) {sel, wen} = d[12:8];
    if (a == 8'h4c && be[2]) {mme, men} = {d[22:20], d[16]};
    for (int i = 0; i < 4; i++) begin
      if (a == 8'h50 && be[i]) ma[8*i +: 8] = d[8*i +: 8];
    end
    if (d3x && !nsr) {wen, sel, men, mme, ma} = '0;
  endtask
  task automatic do_preset(input logic [2:0] s, input logic [7:0] v);
    @(negedge ref_clk);
    {preset_wr, preset_sel, preset_data} = {1'b1, s, v};
    @(negedge ref_clk);
    preset_wr = 1'b0;
    case (s)
      3'h0: dsi = v[0];
      3'h1: aux = v[2:0];
      3'h2: d1 = v[0];
      3'h3: d2 = v[0];
      3'h4: wsup = v[4:0];
      3'h5: nsr = v[0];
      default: dbyte = v;
    endcase
  endtask
  task automatic out_chk();
    repeat (2) @(negedge ref_clk);
    chk({power_state, power_wake_message, msg_irq_enable, intx_allowed, msg_multi_enable,
      downstream_reset_out, msg_addr64_active}, {st, wen, men, !men, mme, 1'b0, men});
    chk(msg_address, {ma[31:2], 2'h0});
  endtask
  task automatic read_all();
    foreach (ofs_tab[i]) do_rd(ofs_tab[i]);
  endtask
  task automatic apply_reset();
    srst = 1'b1;
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    shadow_reset();
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----
  // Clock, watchdog, sequence
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Random phase needs about 1200 cycles; margin is generous
  initial begin
    #200us;
    n_errors++;
    give_verdict();
  end
  initial begin
    logic [7:0] a;
    {srst, preset_wr, preset_sel, preset_data, n_errors, total_checks} = '0;
    lfsr = 32'h24;
    apply_reset();
    read_all();
    foreach (ofs_tab[i]) do_wr(ofs_tab[i], 4'hf, 32'hffffffff);
    read_all();
    for (int s = 0; s < 4; s++) begin
      do_wr(8'h44, 4'h1, 32'(s));
      out_chk();
    end
    do_wr(8'h44, 4'h1, 32'h0);
    do_preset(3'h5, 8'h00);
    do_wr(8'h44, 4'h3, 32'h0000_0103);
    do_wr(8'h4c, 4'h4, 32'h0001_0000);
    do_wr(8'h44, 4'h3, 32'h0000_0100);
    out_chk();
    read_all();
    repeat (300) begin
      repeat (8) lfsr = lfsr_next(lfsr);
      a = ofs_tab[lfsr[10:8] % 6];
      case (lfsr[2:0])
        3'h0, 3'h1, 3'h2: do_wr(a, lfsr[7:4], {lfsr[15:0], lfsr[31:16]});
        3'h6: do_preset(3'(lfsr[13:11] % 7), lfsr[23:16]);
        default: do_rd(a);
      endcase
      out_chk();
    end
    apply_reset();
    read_all();
    out_chk();
    give_verdict();
  end
endmodule // pm_msi_cfg_regs_test
